/* logic/bsfou_pkg.sv */
// Shared constants and types of the bit, shift and flag operation unit.
package bsfou_pkg;

    // Width of a working register and of the status flag byte.
    localparam int unsigned DATA_W = 8;
    // Width of a bit index inside a byte.
    localparam int unsigned INDEX_W = 3;

    // Positions of the status flags inside the flag byte.
    localparam logic [2:0] FLAG_CARRY = 3'h0;
    localparam logic [2:0] FLAG_ZERO  = 3'h1;
    localparam logic [2:0] FLAG_NEG   = 3'h2;
    localparam logic [2:0] FLAG_OVF   = 3'h3;
    localparam logic [2:0] FLAG_SIGN  = 3'h4;
    localparam logic [2:0] FLAG_HALF  = 3'h5;
    localparam logic [2:0] FLAG_T     = 3'h6;
    localparam logic [2:0] FLAG_IRQ   = 3'h7;

    // Value of the flag byte after reset.
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    // Value of the result register after reset.
    localparam logic [7:0] RESULT_RESET = 8'h00;
    // Sign bit and nibble boundaries of a byte.
    localparam int unsigned SIGN_BIT   = 7;
    localparam int unsigned NIBBLE_W   = 4;
    // Cycles from taking an operation to its result being visible.
    localparam int unsigned OP_LATENCY = 1;

    // Operations of this instruction group.
    typedef enum logic [4:0] {
        OP_IDLE,
        OP_CARRY_ROTATE_RIGHT,
        OP_SIGN_KEEP_SHIFT,
        OP_NIBBLE_SWAP,
        OP_STATUS_BIT_RAISE,
        OP_STATUS_BIT_LOWER,
        OP_T_FROM_REG_BIT,
        OP_REG_BIT_FROM_T,
        OP_CARRY_RAISE,
        OP_CARRY_LOWER,
        OP_NEG_RAISE,
        OP_NEG_LOWER,
        OP_ZERO_RAISE,
        OP_ZERO_LOWER,
        OP_IRQ_GLOBAL_ON,
        OP_IRQ_GLOBAL_OFF,
        OP_SIGN_RAISE,
        OP_SIGN_LOWER,
        OP_OVF_RAISE,
        OP_OVF_LOWER,
        OP_T_FLAG_RAISE,
        OP_T_FLAG_LOWER,
        OP_HALF_CARRY_RAISE,
        OP_HALF_CARRY_LOWER
    } bsfou_op_e;

    // Complete registered state of the unit.
    typedef struct packed {
        logic [7:0] flags;
        logic [7:0] result;
        logic       result_write;
    } bsfou_state_s;

    // State after reset.
    localparam bsfou_state_s STATE_RESET = '{
        flags:        FLAGS_RESET,
        result:       RESULT_RESET,
        result_write: 1'b0
    };

    // Flag position that a dedicated raise or lower operation acts on.
    function automatic logic [2:0] bsfou_flag_of(input bsfou_op_e op);
        case (op)
            OP_CARRY_RAISE, OP_CARRY_LOWER:           return FLAG_CARRY;
            OP_NEG_RAISE, OP_NEG_LOWER:               return FLAG_NEG;
            OP_ZERO_RAISE, OP_ZERO_LOWER:             return FLAG_ZERO;
            OP_IRQ_GLOBAL_ON, OP_IRQ_GLOBAL_OFF:      return FLAG_IRQ;
            OP_SIGN_RAISE, OP_SIGN_LOWER:             return FLAG_SIGN;
            OP_OVF_RAISE, OP_OVF_LOWER:               return FLAG_OVF;
            OP_T_FLAG_RAISE, OP_T_FLAG_LOWER:         return FLAG_T;
            OP_HALF_CARRY_RAISE, OP_HALF_CARRY_LOWER: return FLAG_HALF;
            default:                                  return FLAG_CARRY;
        endcase
    endfunction

endpackage

/* logic/bsfou_shifter.sv */
`timescale 1ns/1ns
// Combinational byte shaper: rotate, sign keeping shift, swap and bit insert.
module bsfou_shifter (
    // Operation and operands.
    input  wire bsfou_pkg::bsfou_op_e     i_op,
    input  wire logic [7:0]               i_dest,
    input  wire logic [2:0]               i_bit_index,
    // Flags that feed the shaped byte.
    input  wire logic                     i_carry,
    input  wire logic                     i_t_flag,
    // Shaped byte and the bit that leaves it.
    output logic      [7:0]               o_result,
    output logic                          o_bit_out,
    output logic                          o_writes_dest
);
    import bsfou_pkg::*;

    // Byte moved one place toward bit 0, top bit still open.
    logic [7:0] moved;

    // Each lower bit takes its upper neighbour.
    for (genvar n = 0; n < SIGN_BIT; n++) begin : g_move
        assign moved[n] = i_dest[n+1];
    end
    assign moved[SIGN_BIT] = 1'b0;

    // Pick the byte that the operation leaves in the destination.
    always_comb begin
        o_result      = i_dest;
        o_bit_out     = i_dest[0];
        o_writes_dest = 1'b1;
        case (i_op)
            OP_CARRY_ROTATE_RIGHT: begin
                o_result           = moved;
                o_result[SIGN_BIT] = i_carry;
            end
            OP_SIGN_KEEP_SHIFT: begin
                o_result           = moved;
                o_result[SIGN_BIT] = i_dest[SIGN_BIT];
            end
            OP_NIBBLE_SWAP: begin
                o_result = {i_dest[NIBBLE_W-1:0], i_dest[7:NIBBLE_W]};
            end
            OP_REG_BIT_FROM_T: begin
                o_result[i_bit_index] = i_t_flag;
            end
            default: begin
                o_writes_dest = 1'b0;
            end
        endcase
    end

endmodule // bsfou_shifter

/* logic/bsfou_flag_eval.sv */
`timescale 1ns/1ns
// Combinational flag evaluation for the shift results.
module bsfou_flag_eval (
    // Shaped byte and the carry it produced.
    input  wire logic [7:0] i_result,
    input  wire logic       i_carry,
    // Flags derived from the byte.
    output logic            o_zero,
    output logic            o_neg,
    output logic            o_ovf
);
    import bsfou_pkg::*;

    // Zero on an all-clear byte, negative from the top bit, overflow as
    // negative exclusive-or carry, the usual rule after a right shift.
    always_comb begin
        o_zero = (i_result == 8'h00);
        o_neg  = i_result[SIGN_BIT];
        o_ovf  = i_result[SIGN_BIT] ^ i_carry;
    end

endmodule // bsfou_flag_eval

/* logic/bsfou_unit.sv */
`timescale 1ns/1ns
// What this block does
// - Rotate right through carry, old carry in.
// - Shift right copies bit n+1 to n.
// - Swap upper and lower nibbles at once.
// - Indexed raise or lower one status flag.
// - Register bit to T, T to bit.
// - Dedicated carry raise and lower.
// - Dedicated negative raise and lower.
// - Dedicated zero raise and lower.
// - Global interrupt enable on and off.
// - Dedicated signed test raise and lower.
// - Dedicated overflow raise and lower.
// - Dedicated transfer flag raise and lower.
// - Dedicated half-carry raise.
// - Rotate updates ZCNV; swap, load leave flags.
// - Every operation completes in one cycle.
// - Dedicated half-carry lower.
module bsfou_unit (
    // Clock and reset.
    input  wire logic                   i_core_clk,
    input  wire logic                   i_reset,
    // Operation request from the decoder.
    input  wire logic                   i_op_valid,
    input  wire bsfou_pkg::bsfou_op_e   i_op,
    input  wire logic [2:0]             i_bit_index,
    // Operands read from the register file.
    input  wire logic [7:0]             i_dest_value,
    input  wire logic [7:0]             i_source_value,
    // Write-back toward the register file.
    output logic      [7:0]             o_result,
    output logic                        o_result_write,
    // Status flags.
    output logic      [7:0]             o_status_flags,
    output logic                        o_irq_enable,
    output logic                        o_t_flag
);
    import bsfou_pkg::*;

    // Registered state and its next value.
    bsfou_state_s state;
    bsfou_state_s next_state;

    // Shaped destination byte from the shifter.
    logic [7:0] shaped;
    // Bit that leaves the byte at position 0.
    logic       bit_out;
    // High when the operation writes the destination back.
    logic       writes_dest;
    // Flags derived from the shaped byte.
    logic       eval_zero;
    logic       eval_neg;
    logic       eval_ovf;
    // Carry seen by the flag evaluator: the bit pushed out at position 0.
    logic       eval_carry;

    // Carry out of both right shifts is the old bit 0.
    assign eval_carry = bit_out;

    // Byte shaping is purely combinational so the answer lands in one edge.
    bsfou_shifter u_shifter (
        .i_op          (i_op),
        .i_dest        (i_dest_value),
        .i_bit_index   (i_bit_index),
        .i_carry       (state.flags[FLAG_CARRY]),
        .i_t_flag      (state.flags[FLAG_T]),
        .o_result      (shaped),
        .o_bit_out     (bit_out),
        .o_writes_dest (writes_dest)
    );

    // Flag evaluation of the shaped byte.
    bsfou_flag_eval u_flag_eval (
        .i_result (shaped),
        .i_carry  (eval_carry),
        .o_zero   (eval_zero),
        .o_neg    (eval_neg),
        .o_ovf    (eval_ovf)
    );

    // Next-state logic. Everything an operation changes is decided here and
    // taken at the next edge, so one request costs exactly one cycle and
    // back-to-back requests each see the flags left by the one before.
    always_comb begin
        next_state = state;
        // The write strobe is a one-cycle pulse; it drops unless renewed.
        next_state.result_write = 1'b0;
        if (i_op_valid) begin
            // Result register tracks the shaped byte of a writing op.
            if (writes_dest) begin
                next_state.result       = shaped;
                next_state.result_write = 1'b1;
            end
            case (i_op)
                // Rotate right: carry takes old bit 0, ZNV from the byte.
                OP_CARRY_ROTATE_RIGHT: begin
                    next_state.flags[FLAG_CARRY] = eval_carry;
                    next_state.flags[FLAG_ZERO]  = eval_zero;
                    next_state.flags[FLAG_NEG]   = eval_neg;
                    next_state.flags[FLAG_OVF]   = eval_ovf;
                end
                // Sign keeping shift: same flag treatment as the rotate.
                OP_SIGN_KEEP_SHIFT: begin
                    next_state.flags[FLAG_CARRY] = eval_carry;
                    next_state.flags[FLAG_ZERO]  = eval_zero;
                    next_state.flags[FLAG_NEG]   = eval_neg;
                    next_state.flags[FLAG_OVF]   = eval_ovf;
                end
                // Swap touches no flag at all.
                OP_NIBBLE_SWAP: begin
                    next_state.flags = state.flags;
                end
                // Indexed raise: the position is the flag byte order.
                OP_STATUS_BIT_RAISE: begin
                    next_state.flags[i_bit_index] = 1'b1;
                end
                // Indexed lower: other flags stay as they were.
                OP_STATUS_BIT_LOWER: begin
                    next_state.flags[i_bit_index] = 1'b0;
                end
                // Store: only the transfer flag changes.
                OP_T_FROM_REG_BIT: begin
                    next_state.flags[FLAG_T] = i_source_value[i_bit_index];
                end
                // Load: the byte is written back, flags left untouched.
                OP_REG_BIT_FROM_T: begin
                    next_state.flags = state.flags;
                end
                // Carry raise and lower.
                OP_CARRY_RAISE: begin
                    next_state.flags[bsfou_flag_of(i_op)] = 1'b1;
                end
                OP_CARRY_LOWER: begin
                    next_state.flags[bsfou_flag_of(i_op)] = 1'b0;
                end
                // Negative raise and lower.
                OP_NEG_RAISE: begin
                    next_state.flags[bsfou_flag_of(i_op)] = 1'b1;
                end
                OP_NEG_LOWER: begin
                    next_state.flags[bsfou_flag_of(i_op)] = 1'b0;
                end
                // Zero raise and lower.
                OP_ZERO_RAISE: begin
                    next_state.flags[bsfou_flag_of(i_op)] = 1'b1;
                end
                OP_ZERO_LOWER: begin
                    next_state.flags[bsfou_flag_of(i_op)] = 1'b0;
                end
                // Global interrupt enable on and off. The enable is seen by
                // the interrupt logic from the cycle after the edge.
                OP_IRQ_GLOBAL_ON: begin
                    next_state.flags[bsfou_flag_of(i_op)] = 1'b1;
                end
                OP_IRQ_GLOBAL_OFF: begin
                    next_state.flags[bsfou_flag_of(i_op)] = 1'b0;
                end
                // Signed test raise and lower.
                OP_SIGN_RAISE: begin
                    next_state.flags[bsfou_flag_of(i_op)] = 1'b1;
                end
                OP_SIGN_LOWER: begin
                    next_state.flags[bsfou_flag_of(i_op)] = 1'b0;
                end
                // Overflow raise and lower.
                OP_OVF_RAISE: begin
                    next_state.flags[bsfou_flag_of(i_op)] = 1'b1;
                end
                OP_OVF_LOWER: begin
                    next_state.flags[bsfou_flag_of(i_op)] = 1'b0;
                end
                // Transfer flag raise and lower.
                OP_T_FLAG_RAISE: begin
                    next_state.flags[bsfou_flag_of(i_op)] = 1'b1;
                end
                OP_T_FLAG_LOWER: begin
                    next_state.flags[bsfou_flag_of(i_op)] = 1'b0;
                end
                // Half-carry raise and lower.
                OP_HALF_CARRY_RAISE: begin
                    next_state.flags[bsfou_flag_of(i_op)] = 1'b1;
                end
                OP_HALF_CARRY_LOWER: begin
                    next_state.flags[bsfou_flag_of(i_op)] = 1'b0;
                end
                // Idle or unknown code: nothing changes.
                default: begin
                    next_state.flags = state.flags;
                end
            endcase
        end
    end

    // State register. Reset is synchronous so the unit only ever changes
    // on a core clock edge, matching the rest of the core pipeline.
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            state <= STATE_RESET;
        end else begin
            state <= next_state;
        end
    end

    // Outputs come straight from the state register.
    assign o_result       = state.result;
    assign o_result_write = state.result_write;
    assign o_status_flags = state.flags;
    assign o_irq_enable   = state.flags[FLAG_IRQ];
    assign o_t_flag       = state.flags[FLAG_T];

endmodule // bsfou_unit

/* verif/bsfou_unit_asserts.sv */
`timescale 1ns/1ns
// Port-level timing and value checks of the bit, shift and flag unit.
module bsfou_unit_asserts
    import bsfou_pkg::*;
(
    // Clock and reset.
    input wire logic                 i_core_clk,
    input wire logic                 i_reset,
    // Request side.
    input wire logic                 i_op_valid,
    input wire bsfou_pkg::bsfou_op_e i_op,
    input wire logic [2:0]           i_bit_index,
    input wire logic [7:0]           i_dest_value,
    input wire logic [7:0]           i_source_value,
    // Observed outputs.
    input wire logic [7:0]           o_result,
    input wire logic                 o_result_write,
    input wire logic [7:0]           o_status_flags,
    input wire logic                 o_irq_enable,
    input wire logic                 o_t_flag
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_reset);
    // High when the request must write a byte back.
    logic wr_op;
    assign wr_op = i_op_valid && (i_op inside {OP_CARRY_ROTATE_RIGHT, OP_SIGN_KEEP_SHIFT,
        OP_NIBBLE_SWAP, OP_REG_BIT_FROM_T});
    wr_pulse_a: assert property (wr_op |=> o_result_write)
        else $error("write pulse missing");
    no_wr_a: assert property (!wr_op |=> !o_result_write)
        else $error("stray write pulse");
    rot_val_a: assert property (i_op_valid && i_op == OP_CARRY_ROTATE_RIGHT |=>
        o_result == {$past(o_status_flags[0]), $past(i_dest_value[7:1])}
        && o_status_flags[0] == $past(i_dest_value[0])) else $error("rotate wrong");
    shift_val_a: assert property (i_op_valid && i_op == OP_SIGN_KEEP_SHIFT |=>
        o_result == {$past(i_dest_value[7]), $past(i_dest_value[7:1])}
        && o_status_flags[0] == $past(i_dest_value[0])) else $error("shift wrong");
    swap_val_a: assert property (i_op_valid && i_op == OP_NIBBLE_SWAP |=>
        o_result == {$past(i_dest_value[3:0]), $past(i_dest_value[7:4])}
        && $stable(o_status_flags)) else $error("swap wrong");
    idx_raise_a: assert property (i_op_valid && i_op == OP_STATUS_BIT_RAISE |=>
        o_status_flags == ($past(o_status_flags) | (8'h01 << $past(i_bit_index))))
        else $error("indexed raise wrong");
    idx_lower_a: assert property (i_op_valid && i_op == OP_STATUS_BIT_LOWER |=>
        o_status_flags == ($past(o_status_flags) & ~(8'h01 << $past(i_bit_index))))
        else $error("indexed lower wrong");
    t_store_a: assert property (i_op_valid && i_op == OP_T_FROM_REG_BIT |=>
        o_t_flag == $past(i_source_value[i_bit_index])
        && (o_status_flags & 8'hBF) == ($past(o_status_flags) & 8'hBF))
        else $error("bit store wrong");
    t_load_a: assert property (i_op_valid && i_op == OP_REG_BIT_FROM_T |=>
        o_result[$past(i_bit_index)] == $past(o_t_flag) && $stable(o_status_flags))
        else $error("bit load wrong");
    carry_ded_a: assert property (i_op_valid && i_op inside {OP_CARRY_RAISE,
        OP_CARRY_LOWER} |=> o_status_flags[0] == ($past(i_op) == OP_CARRY_RAISE))
        else $error("carry force wrong");
    idle_hold_a: assert property (!i_op_valid |=> $stable(o_status_flags)
        && $stable(o_result)) else $error("state moved while idle");
    flag_map_a: assert property (o_irq_enable == o_status_flags[7]
        && o_t_flag == o_status_flags[6]) else $error("flag mirrors wrong");
    // Main scenarios seen at least once.
    cover property (i_op_valid && i_op == OP_CARRY_ROTATE_RIGHT && o_status_flags[0]);
    cover property (o_result_write [*2]);
    cover property (i_op_valid && i_op == OP_T_FROM_REG_BIT);
endmodule // bsfou_unit_asserts

/* verif/bsfou_regfile_model.sv */
`timescale 1ns/1ns
// Register file stand-in: one destination register with a write-back bypass.
module bsfou_regfile_model (
    // Clock and reset.
    input  wire logic       i_core_clk,
    input  wire logic       i_reset,
    // Fresh operand from the bench.
    input  wire logic       i_load,
    input  wire logic [7:0] i_load_value,
    // Write-back from the unit.
    input  wire logic       i_result_write,
    input  wire logic [7:0] i_result,
    // Operand toward the unit.
    output logic      [7:0] o_dest_value
);
    // Stored destination register.
    logic [7:0] dest_reg;
    // Bypass the fresh result, since back-to-back ops must see it without a stall.
    always_comb begin
        o_dest_value = i_load ? i_load_value : (i_result_write ? i_result : dest_reg);
    end
    // The register keeps whatever the unit last saw.
    always_ff @(posedge i_core_clk) begin
        dest_reg <= i_reset ? 8'h00 : o_dest_value;
    end
endmodule // bsfou_regfile_model

/* verif/bsfou_unit_tb_top.sv */
`timescale 1ns/1ns
// Self-checking bench of the bit, shift and flag unit.
module bsfou_unit_tb_top;
    import bsfou_pkg::*;
    logic i_core_clk, i_reset, i_op_valid, load, o_result_write, o_irq_enable, o_t_flag;
    bsfou_op_e  i_op;
    logic [2:0] i_bit_index;
    logic [7:0] i_source_value, load_val, dest_value, o_result, o_status_flags;
    logic [7:0] m_flags, m_res, m_reg;  // Expected state.
    logic       m_wr;
    logic [31:0] rng;
    int bad_count, n_compared;
    // Flag position of each dedicated raise and lower pair, in op order.
    localparam logic [2:0] POS [8] = '{3'h0, 3'h2, 3'h1, 3'h7, 3'h4, 3'h3, 3'h6, 3'h5};

    bsfou_unit bsfou_unit_inst (.i_core_clk, .i_reset, .i_op_valid, .i_op, .i_bit_index,
        .i_dest_value(dest_value), .i_source_value, .o_result, .o_result_write,
        .o_status_flags, .o_irq_enable, .o_t_flag);
    bsfou_regfile_model bsfou_regfile_model_inst (.i_core_clk, .i_reset, .i_load(load),
        .i_load_value(load_val), .i_result_write(o_result_write), .i_result(o_result),
        .o_dest_value(dest_value));

    initial begin
        i_core_clk = 1'b0;
        forever #10 i_core_clk = ~i_core_clk;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic check_out();
        chk(o_status_flags, m_flags);
        chk(o_result, m_res);
        chk({7'h00, o_result_write}, {7'h00, m_wr});
        chk({6'h00, o_irq_enable, o_t_flag}, {6'h00, m_flags[7:6]});
    endtask

    // Works out the unit's next state for one accepted op.
    task automatic predict(input bsfou_op_e o, input logic [2:0] x, input logic [7:0] s,
                           input logic [7:0] d);
        logic [7:0] r;
        int k;
        r = d;
        k = int'(o) - 8;
        m_wr = 1'b1;
        case (o)
            OP_CARRY_ROTATE_RIGHT, OP_SIGN_KEEP_SHIFT: begin
                r = {(o == OP_SIGN_KEEP_SHIFT) ? d[7] : m_flags[0], d[7:1]};
                m_flags[0] = d[0];
                m_flags[1] = (r == 8'h00);
                m_flags[2] = r[7];
                m_flags[3] = r[7] ^ d[0];
            end
            OP_NIBBLE_SWAP: r = {d[3:0], d[7:4]};
            OP_REG_BIT_FROM_T: r[x] = m_flags[6];
            default: begin
                m_wr = 1'b0;
                if (o == OP_STATUS_BIT_RAISE) m_flags[x] = 1'b1;
                else if (o == OP_STATUS_BIT_LOWER) m_flags[x] = 1'b0;
                else if (o == OP_T_FROM_REG_BIT) m_flags[6] = s[x];
                else if (k >= 0) m_flags[POS[k/2]] = (k % 2 == 0);
            end
        endcase
        if (m_wr) m_res = r;
    endtask

    // Drives one request for the next edge and checks the result of the one taken at the edge before.
    task automatic step(input logic v, input bsfou_op_e o, input logic [2:0] x,
                        input logic [7:0] s, input logic ld, input logic [7:0] lv);
        logic [7:0] d;
        d = ld ? lv : m_reg;
        i_op_valid <= v;
        i_op <= o;
        i_bit_index <= x;
        i_source_value <= s;
        load <= ld;
        load_val <= lv;
        @(negedge i_core_clk);
        check_out();
        m_wr = 1'b0;
        if (v) predict(o, x, s, d);
        m_reg = m_wr ? m_res : d;
        @(posedge i_core_clk);
    endtask

    task automatic do_reset(input int n);
        i_reset <= 1'b1;
        i_op_valid <= 1'b0;
        repeat (n) @(posedge i_core_clk);
        i_reset <= 1'b0;
        m_flags = 8'h00;
        m_res = 8'h00;
        m_reg = 8'h00;
        m_wr = 1'b0;
    endtask

    task automatic test_done();
        $display("compared=%0d mismatches=%0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Cuts the run short if the sequence ever stalls.
    initial begin
        #1000000;
        bad_count++;
        test_done();
    end

    initial begin
        {i_op_valid, load, i_bit_index, i_source_value, load_val} = '0;
        // Reset from time zero, so no check sees the unit's unset state.
        i_reset = 1'b1;
        i_op = OP_IDLE;
        rng = 32'h00004F82;
        n_compared = 0;
        bad_count = 0;
        @(posedge i_core_clk);
        do_reset(12);
        step(1'b1, OP_CARRY_ROTATE_RIGHT, 3'h0, 8'h00, 1'b1, 8'h81);
        // Every op back to back at both index extremes, then a mid-run reset.
        for (int p = 0; p < 2; p++) begin
            for (int k = 0; k < 24; k++) begin
                rng = xs(rng);
                step(1'b1, bsfou_op_e'(k), p ? 3'h7 : 3'h0, rng[7:0], rng[8], rng[16:9]);
            end
        end
        do_reset(2);
        for (int n = 0; n < 3000; n++) begin
            rng = xs(rng);
            step(rng[5] | rng[6], bsfou_op_e'(rng[4:0] % 5'h18), rng[9:7], rng[17:10],
                 rng[18], rng[26:19]);
        end
        @(negedge i_core_clk);
        check_out();
        test_done();
    end
endmodule // bsfou_unit_tb_top

bind bsfou_unit bsfou_unit_asserts bsfou_unit_asserts_inst (.i_core_clk, .i_reset,
    .i_op_valid, .i_op, .i_bit_index, .i_dest_value, .i_source_value, .o_result,
    .o_result_write, .o_status_flags, .o_irq_enable, .o_t_flag);
